/* File: common/sme_pkg.sv */
// Constants, field positions and types for the shift/move/indirect datapath
package sme_pkg;

    // Widths
    localparam int DATA_W    = 8;
    localparam int FILE_AW   = 7;
    localparam int PTR_W     = 16;
    localparam int MEM_AW    = 8;
    localparam int MEM_DEPTH = 256;
    localparam int OFS_W     = 6;
    localparam int REG_AW    = 4;

    // Register port offsets
    localparam logic [REG_AW-1:0] REG_WORK     = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS   = 4'h1;
    localparam logic [REG_AW-1:0] REG_PTR0_LO  = 4'h2;
    localparam logic [REG_AW-1:0] REG_PTR0_HI  = 4'h3;
    localparam logic [REG_AW-1:0] REG_PTR1_LO  = 4'h4;
    localparam logic [REG_AW-1:0] REG_PTR1_HI  = 4'h5;
    localparam logic [REG_AW-1:0] REG_MEM_ADDR = 4'h6;
    localparam logic [REG_AW-1:0] REG_MEM_DATA = 4'h7;
    localparam logic [REG_AW-1:0] REG_EA_LO    = 4'h8;
    localparam logic [REG_AW-1:0] REG_EA_HI    = 4'h9;

    // Status fields
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 1;

    // Window register file addresses
    localparam logic [FILE_AW-1:0] WIN0_ADDR = 7'h00;
    localparam logic [FILE_AW-1:0] WIN1_ADDR = 7'h01;

    // Reset values
    localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
    localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
    localparam logic [MEM_AW-1:0] MADDR_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // Encodings
    localparam logic       DEST_WORK = 1'b0;
    localparam logic       DEST_FILE = 1'b1;
    localparam logic [1:0] MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;

    typedef enum logic [1:0] {
        SME_OP_NONE,
        SME_OP_SHIFT,
        SME_OP_COPY,
        SME_OP_LOAD
    } sme_op_e;

    function automatic logic sme_is_zero(input logic [DATA_W-1:0] v);
        return (v == ZERO_BYTE);
    endfunction : sme_is_zero

endpackage : sme_pkg

/* File: common/sme_dp_if.sv */
// Carrier between the controller, the shifter and the pointer unit
`timescale 1ns/1ps
`default_nettype none
interface sme_dp_if;
    import sme_pkg::*;
    sme_op_e                 op;
    logic [DATA_W-1:0]       operand;
    logic [DATA_W-1:0]       result;
    logic                    carry_out;
    logic                    carry_we;
    logic                    zero;
    logic [PTR_W-1:0]        ptr_cur;
    logic [1:0]              mode;
    logic                    rel;
    logic [OFS_W-1:0]        offset;
    logic [PTR_W-1:0]        ea;
    logic [PTR_W-1:0]        ptr_next;

    modport ctl (output op, operand, ptr_cur, mode, rel, offset,
                 input  result, carry_out, carry_we, zero, ea, ptr_next);
    modport alu (input  op, operand,
                 output result, carry_out, carry_we, zero);
    modport ptr (input  ptr_cur, mode, rel, offset,
                 output ea, ptr_next);
endinterface : sme_dp_if
`default_nettype wire

/* File: src/sme_alu.sv */
// Shift and pass-through unit with zero detection
`timescale 1ns/1ps
`default_nettype none
module sme_alu (
    // Datapath carrier
    sme_dp_if.alu dp
);
    import sme_pkg::*;

    always_comb begin
        dp.result    = dp.operand;
        dp.carry_out = 1'b0;
        dp.carry_we  = 1'b0;
        case (dp.op)
            SME_OP_SHIFT: begin
                dp.result    = {1'b0, dp.operand[DATA_W-1:1]};
                dp.carry_out = dp.operand[0];
                dp.carry_we  = 1'b1;
            end
            SME_OP_COPY: begin
                dp.result = dp.operand;
            end
            SME_OP_LOAD: begin
                dp.result = dp.operand;
            end
            default: begin
                dp.result = dp.operand;
            end
        endcase
        dp.zero = sme_is_zero(dp.result);
    end

endmodule : sme_alu
`default_nettype wire

/* File: src/sme_ptr.sv */
// Effective address and pointer step for the indirect load
`timescale 1ns/1ps
`default_nettype none
module sme_ptr (
    // Datapath carrier
    sme_dp_if.ptr dp
);
    import sme_pkg::*;

    logic [PTR_W-1:0] ofs_ext;
    logic [PTR_W-1:0] ptr_inc;
    logic [PTR_W-1:0] ptr_dec;

    // Modular 16-bit arithmetic gives the wrap at both ends
    assign ofs_ext = {{(PTR_W-OFS_W){dp.offset[OFS_W-1]}}, dp.offset};
    assign ptr_inc = dp.ptr_cur + PTR_STEP;
    assign ptr_dec = dp.ptr_cur - PTR_STEP;

    always_comb begin
        dp.ea       = dp.ptr_cur;
        dp.ptr_next = dp.ptr_cur;
        if (dp.rel) begin
            dp.ea       = dp.ptr_cur + ofs_ext;
            dp.ptr_next = dp.ptr_cur;
        end else begin
            case (dp.mode)
                MODE_PRE_INC: begin
                    dp.ea       = ptr_inc;
                    dp.ptr_next = ptr_inc;
                end
                MODE_PRE_DEC: begin
                    dp.ea       = ptr_dec;
                    dp.ptr_next = ptr_dec;
                end
                MODE_POST_INC: begin
                    dp.ea       = dp.ptr_cur;
                    dp.ptr_next = ptr_inc;
                end
                MODE_POST_DEC: begin
                    dp.ea       = dp.ptr_cur;
                    dp.ptr_next = ptr_dec;
                end
                default: begin
                    dp.ea       = dp.ptr_cur;
                    dp.ptr_next = dp.ptr_cur;
                end
            endcase
        end
    end

endmodule : sme_ptr
`default_nettype wire

/* File: src/sme_exec.sv */
// Top of the shift/move/indirect-load execution datapath
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sme_exec (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    // Instruction issue
    input  wire logic                        i_exec_valid,
    input  wire sme_pkg::sme_op_e            i_op,
    input  wire logic [sme_pkg::FILE_AW-1:0] i_file_addr,
    input  wire logic                        i_dest,
    input  wire logic                        i_ptr_sel,
    input  wire logic [1:0]                  i_mode,
    input  wire logic                        i_rel,
    input  wire logic [sme_pkg::OFS_W-1:0]   i_offset,
    // Register port
    input  wire logic [sme_pkg::REG_AW-1:0]  i_reg_addr,
    input  wire logic [sme_pkg::DATA_W-1:0]  i_reg_wdata,
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    output logic      [sme_pkg::DATA_W-1:0]  o_reg_rdata,
    // Core state
    output logic                             o_done,
    output logic      [sme_pkg::DATA_W-1:0]  o_work,
    output logic                             o_carry,
    output logic                             o_zero,
    output logic      [sme_pkg::PTR_W-1:0]   o_ptr0,
    output logic      [sme_pkg::PTR_W-1:0]   o_ptr1
);
    import sme_pkg::*;

    // Reset release
    logic                rst_meta_reg;
    logic                rst_sync_reg;
    logic                rst_n;

    // Architectural state
    logic [DATA_W-1:0]   work_reg;
    logic                carry_reg;
    logic                zero_reg;
    logic [PTR_W-1:0]    ptr0_reg;
    logic [PTR_W-1:0]    ptr1_reg;
    logic [PTR_W-1:0]    ea_reg;
    logic [MEM_AW-1:0]   maddr_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic                done_reg;
    logic [DATA_W-1:0]   mem [MEM_DEPTH];

    // Decode
    logic                go_shift;
    logic                go_copy;
    logic                go_load;
    logic                go_file_op;
    logic                is_window;
    logic [PTR_W-1:0]    window_ptr;
    logic [MEM_AW-1:0]   file_idx;
    logic [MEM_AW-1:0]   load_idx;
    logic [DATA_W-1:0]   file_val;
    logic [DATA_W-1:0]   load_val;
    logic                wr_work;
    logic                wr_file;
    logic                wr_ptr0;
    logic                wr_ptr1;
    logic [DATA_W-1:0]   rd_mux;

    sme_dp_if dp ();

    // Port write hit for one register offset
    function automatic logic port_hit(
        input logic              wr,
        input logic [REG_AW-1:0] addr,
        input logic [REG_AW-1:0] target
    );
        return wr && (addr == target);
    endfunction : port_hit

    // Replace one byte lane of a pointer-sized word
    function automatic logic [PTR_W-1:0] lane_merge(
        input logic [PTR_W-1:0]  cur,
        input logic [DATA_W-1:0] byte_in,
        input logic              hi
    );
        logic [PTR_W-1:0] merged;
        merged = cur;
        if (hi) begin
            merged[PTR_W-1:DATA_W] = byte_in;
        end else begin
            merged[DATA_W-1:0] = byte_in;
        end
        return merged;
    endfunction : lane_merge

    // Select one byte lane of a pointer-sized word for the port
    function automatic logic [DATA_W-1:0] lane_pick(
        input logic [PTR_W-1:0] word,
        input logic             hi
    );
        return hi ? word[PTR_W-1:DATA_W] : word[DATA_W-1:0];
    endfunction : lane_pick

    // Async assert, two-stage release avoids recovery hazards downstream
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // Instruction decode
    assign go_shift   = i_exec_valid && (i_op == SME_OP_SHIFT);
    assign go_copy    = i_exec_valid && (i_op == SME_OP_COPY);
    assign go_load    = i_exec_valid && (i_op == SME_OP_LOAD);
    assign go_file_op = go_shift || go_copy;

    // Window registers hold nothing; the address comes from the pointer
    always_comb begin
        is_window  = 1'b0;
        window_ptr = ptr0_reg;
        if (i_file_addr == WIN0_ADDR) begin
            is_window  = 1'b1;
            window_ptr = ptr0_reg;
        end else if (i_file_addr == WIN1_ADDR) begin
            is_window  = 1'b1;
            window_ptr = ptr1_reg;
        end
    end

    // Only the low pointer bits reach the local data memory
    assign file_idx = is_window ? window_ptr[MEM_AW-1:0]
                                : {1'b0, i_file_addr};
    assign file_val = mem[file_idx];

    // Indirect load path through the pointer unit
    assign dp.ptr_cur = i_ptr_sel ? ptr1_reg : ptr0_reg;
    assign dp.mode    = i_mode;
    assign dp.rel     = i_rel;
    assign dp.offset  = i_offset;
    assign load_idx   = dp.ea[MEM_AW-1:0];
    assign load_val   = mem[load_idx];

    // Shared shift/pass unit
    always_comb begin
        dp.op      = SME_OP_NONE;
        dp.operand = file_val;
        if (go_shift) begin
            dp.op = SME_OP_SHIFT;
        end else if (go_copy) begin
            dp.op = SME_OP_COPY;
        end else if (go_load) begin
            dp.op      = SME_OP_LOAD;
            dp.operand = load_val;
        end
    end

    sme_alu u_alu (
        .dp (dp.alu)
    );

    sme_ptr u_ptr (
        .dp (dp.ptr)
    );

    // Destination steering
    assign wr_work = (go_file_op && (i_dest == DEST_WORK))
                     || go_load;
    assign wr_file = go_file_op && (i_dest == DEST_FILE);
    assign wr_ptr0 = go_load && !i_ptr_sel && !i_rel;
    assign wr_ptr1 = go_load && i_ptr_sel && !i_rel;

    // Working register; an instruction beats a same-cycle port write
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg <= WORK_RST;
        end else if (wr_work) begin
            work_reg <= dp.result;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_WORK)) begin
            work_reg <= i_reg_wdata;
        end
    end

    // Carry changes only on the shift or on a port write to the status register
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_reg <= 1'b0;
        end else if (go_shift && dp.carry_we) begin
            carry_reg <= dp.carry_out;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_STATUS)) begin
            carry_reg <= i_reg_wdata[STAT_C_BIT];
        end
    end

    // Zero follows every result here, file destination included
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_reg <= 1'b0;
        end else if (go_file_op || go_load) begin
            zero_reg <= dp.zero;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_STATUS)) begin
            zero_reg <= i_reg_wdata[STAT_Z_BIT];
        end
    end

    // Pointer 0
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr0_reg <= PTR_RST;
        end else if (wr_ptr0) begin
            ptr0_reg <= dp.ptr_next;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_PTR0_LO)) begin
            ptr0_reg <= lane_merge(ptr0_reg, i_reg_wdata, 1'b0);
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_PTR0_HI)) begin
            ptr0_reg <= lane_merge(ptr0_reg, i_reg_wdata, 1'b1);
        end
    end

    // Pointer 1
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr1_reg <= PTR_RST;
        end else if (wr_ptr1) begin
            ptr1_reg <= dp.ptr_next;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_PTR1_LO)) begin
            ptr1_reg <= lane_merge(ptr1_reg, i_reg_wdata, 1'b0);
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_PTR1_HI)) begin
            ptr1_reg <= lane_merge(ptr1_reg, i_reg_wdata, 1'b1);
        end
    end

    // Last effective address, kept for software inspection
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ea_reg <= PTR_RST;
        end else if (go_load) begin
            ea_reg <= dp.ea;
        end
    end

    // Memory address used by the port's data window
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            maddr_reg <= MADDR_RST;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_MEM_ADDR)) begin
            maddr_reg <= i_reg_wdata;
        end
    end

    // Data memory has no reset; software must initialise it
    always_ff @(posedge i_clk) begin
        if (wr_file) begin
            mem[file_idx] <= dp.result;
        end else if (port_hit(i_reg_wr, i_reg_addr, REG_MEM_DATA)) begin
            mem[maddr_reg] <= i_reg_wdata;
        end
    end

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = ZERO_BYTE;
        case (i_reg_addr)
            REG_WORK: begin
                rd_mux = work_reg;
            end
            REG_STATUS: begin
                rd_mux             = ZERO_BYTE;
                rd_mux[STAT_C_BIT] = carry_reg;
                rd_mux[STAT_Z_BIT] = zero_reg;
            end
            REG_PTR0_LO: begin
                rd_mux = lane_pick(ptr0_reg, 1'b0);
            end
            REG_PTR0_HI: begin
                rd_mux = lane_pick(ptr0_reg, 1'b1);
            end
            REG_PTR1_LO: begin
                rd_mux = lane_pick(ptr1_reg, 1'b0);
            end
            REG_PTR1_HI: begin
                rd_mux = lane_pick(ptr1_reg, 1'b1);
            end
            REG_MEM_ADDR: begin
                rd_mux = maddr_reg;
            end
            REG_MEM_DATA: begin
                rd_mux = mem[maddr_reg];
            end
            REG_EA_LO: begin
                rd_mux = lane_pick(ea_reg, 1'b0);
            end
            REG_EA_HI: begin
                rd_mux = lane_pick(ea_reg, 1'b1);
            end
            default: begin
                rd_mux = ZERO_BYTE;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= ZERO_BYTE;
        end else if (i_reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= ZERO_BYTE;
        end
    end

    // Completion pulse, one cycle after issue
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= go_file_op || go_load;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_done      = done_reg;
    assign o_work      = work_reg;
    assign o_carry     = carry_reg;
    assign o_zero      = zero_reg;
    assign o_ptr0      = ptr0_reg;
    assign o_ptr1      = ptr1_reg;

endmodule : sme_exec
`default_nettype wire

/* File: test/sme_exec_asserts.sv */
// Port-level checker for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module sme_exec_chk
    import sme_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_exec_valid,
    input wire sme_pkg::sme_op_e i_op,
    input wire logic             i_dest,
    input wire logic             i_ptr_sel,
    input wire logic [1:0]       i_mode,
    input wire logic             i_rel,
    input wire logic             i_reg_wr,
    input wire logic [7:0]       o_work,
    input wire logic             o_carry,
    input wire logic             o_zero,
    input wire logic [15:0]      o_ptr0,
    input wire logic [15:0]      o_ptr1
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Port writes excluded: instruction wins, but keep antecedents clean
    wire logic sh = i_exec_valid && !i_reg_wr && i_op == SME_OP_SHIFT;
    wire logic cp = i_exec_valid && !i_reg_wr && i_op == SME_OP_COPY;
    wire logic ld = i_exec_valid && !i_reg_wr && i_op == SME_OP_LOAD;

    property p_shift_top;
        sh && i_dest == DEST_WORK
            |=> !o_work[7] && o_zero == (o_work == 8'h00);
    endproperty
    a_shift_top: assert property (p_shift_top)
        else $error("shift top bit or zero flag wrong");
    property p_copy_zero;
        cp && i_dest == DEST_WORK |=> o_zero == (o_work == 8'h00);
    endproperty
    a_copy_zero: assert property (p_copy_zero)
        else $error("copy zero flag wrong");
    property p_file_keep;
        (sh || cp) && i_dest == DEST_FILE |=> $stable(o_work);
    endproperty
    a_file_keep: assert property (p_file_keep)
        else $error("file destination changed work");
    property p_ld_carry;
        ld |=> $stable(o_carry);
    endproperty
    a_ld_carry: assert property (p_ld_carry)
        else $error("load changed carry");
    property p_ld_zero;
        ld |=> o_zero == (o_work == 8'h00);
    endproperty
    a_ld_zero: assert property (p_ld_zero)
        else $error("load zero flag wrong");
    property p_rel_hold;
        ld && i_rel |=> $stable(o_ptr0) && $stable(o_ptr1);
    endproperty
    a_rel_hold: assert property (p_rel_hold)
        else $error("relative load moved a pointer");
    property p_ptr0_inc;
        ld && !i_rel && !i_ptr_sel && !i_mode[0]
            |=> o_ptr0 == $past(o_ptr0) + 16'h0001;
    endproperty
    a_ptr0_inc: assert property (p_ptr0_inc)
        else $error("pointer0 increment wrong");
    property p_ptr1_dec;
        ld && !i_rel && i_ptr_sel && i_mode[0]
            |=> o_ptr1 == $past(o_ptr1) - 16'h0001;
    endproperty
    a_ptr1_dec: assert property (p_ptr1_dec)
        else $error("pointer1 decrement wrong");
endmodule : sme_exec_chk
bind sme_exec sme_exec_chk i_chk (.i_clk, .i_rst_n, .i_exec_valid, .i_op,
    .i_dest, .i_ptr_sel, .i_mode, .i_rel, .i_reg_wr, .o_work, .o_carry,
    .o_zero, .o_ptr0, .o_ptr1);
`default_nettype wire

/* File: test/test_sme_exec.sv */
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`default_nettype none
module test_sme_exec;
    import sme_pkg::*;
    logic              i_clk, i_rst_n, i_exec_valid, i_dest, i_ptr_sel;
    sme_op_e           i_op;
    logic [6:0]        i_file_addr;
    logic [1:0]        i_mode;
    logic              i_rel, i_reg_wr, i_reg_rd, o_done, o_carry, o_zero;
    logic [5:0]        i_offset;
    logic [3:0]        i_reg_addr;
    logic [7:0]        i_reg_wdata, o_reg_rdata, o_work, m_work, rd;
    logic [15:0]       o_ptr0, o_ptr1, m_p0, m_p1, m_ea;
    logic [7:0]        m_mem [MEM_DEPTH];
    logic              m_c, m_z;
    logic [31:0]       rs = 32'h670B;
    int                failures = 0;
    int                samples_checked = 0;

    sme_exec i_dut (.i_clk, .i_rst_n, .i_exec_valid, .i_op, .i_file_addr,
        .i_dest, .i_ptr_sel, .i_mode, .i_rel, .i_offset, .i_reg_addr,
        .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_done, .o_work,
        .o_carry, .o_zero, .o_ptr0, .o_ptr1);

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // Strobe rises one edge after entry, so back-to-back calls never clash
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk);
        i_reg_wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd   <= 1'b0;
        #1;
        v = o_reg_rdata;
    endtask : reg_rd

    task automatic set_ptr(input logic s, input logic [15:0] v);
        reg_wr(s ? REG_PTR1_LO : REG_PTR0_LO, v[7:0]);
        reg_wr(s ? REG_PTR1_HI : REG_PTR0_HI, v[15:8]);
        if (s) m_p1 = v;
        else m_p0 = v;
    endtask : set_ptr

    function automatic void model(sme_op_e op, logic [6:0] fa, logic d,
        logic s, logic [1:0] m, logic r, logic [5:0] k);
        logic [7:0]  a, v, res;
        logic [15:0] p, np;
        a = (fa == WIN0_ADDR) ? m_p0[7:0] :
            (fa == WIN1_ADDR) ? m_p1[7:0] : {1'b0, fa};
        v = m_mem[a];
        p = s ? m_p1 : m_p0;
        if (op == SME_OP_LOAD) begin
            m_ea = r ? p + {{10{k[5]}}, k} :
                (m == MODE_PRE_INC) ? p + 16'h0001 :
                (m == MODE_PRE_DEC) ? p - 16'h0001 : p;
            np = r ? p : m[0] ? p - 16'h0001 : p + 16'h0001;
            m_work = m_mem[m_ea[7:0]];
            m_z = (m_work == 8'h00);
            if (s) m_p1 = np;
            else m_p0 = np;
        end else if (op != SME_OP_NONE) begin
            res = (op == SME_OP_SHIFT) ? {1'b0, v[7:1]} : v;
            if (op == SME_OP_SHIFT) m_c = v[0];
            m_z = (res == 8'h00);
            if (d == DEST_WORK) m_work = res;
            else m_mem[a] = res;
        end
    endfunction : model

    task automatic exec(input sme_op_e op, input logic [6:0] fa,
        input logic d, input logic s, input logic [1:0] m, input logic r,
        input logic [5:0] k);
        @(posedge i_clk);
        i_exec_valid <= 1'b1;
        i_op         <= op;
        i_file_addr  <= fa;
        i_dest       <= d;
        i_ptr_sel    <= s;
        i_mode       <= m;
        i_rel        <= r;
        i_offset     <= k;
        @(posedge i_clk);
        i_exec_valid <= 1'b0;
        #1;
        model(op, fa, d, s, m, r, k);
        check(o_done, op != SME_OP_NONE);
        check(o_work, m_work);
        check({o_carry, o_zero}, {m_c, m_z});
        check(o_ptr0, m_p0);
        check(o_ptr1, m_p1);
    endtask : exec

    initial begin
        #100000;
        failures++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        {i_rst_n, i_exec_valid, i_dest, i_ptr_sel, i_rel} = 5'h00;
        {i_reg_wr, i_reg_rd, i_mode, i_offset, i_file_addr} = 17'h00000;
        {i_reg_addr, i_reg_wdata} = 12'h000;
        i_op = SME_OP_NONE;
        {m_work, m_c, m_z, m_p0, m_p1} = 42'h0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check(o_work, WORK_RST);
        check(o_ptr0, PTR_RST);
        check(o_ptr1, PTR_RST);
        check({o_carry, o_zero, o_done}, 3'h0);
        // Every fourth byte zero so the zero flag is exercised often
        for (int i = 0; i < MEM_DEPTH; i++) begin
            m_mem[i] = (i % 4 == 0) ? 8'h00 : 8'(rnd());
            reg_wr(REG_MEM_ADDR, 8'(i));
            reg_wr(REG_MEM_DATA, m_mem[i]);
        end
        set_ptr(1'b0, 16'hFFFF);
        exec(SME_OP_LOAD, 7'h00, 1'b0, 1'b0, MODE_PRE_INC, 1'b0, 6'h00);
        set_ptr(1'b1, 16'h0000);
        exec(SME_OP_LOAD, 7'h00, 1'b0, 1'b1, MODE_POST_DEC, 1'b0, 6'h00);
        for (int i = 0; i < 4; i++) begin
            exec(SME_OP_LOAD, 7'h00, 1'b0, 1'(i), 2'(i), 1'b1, 6'h20 - 6'(i));
            reg_rd(REG_EA_LO, rd);
            check(rd, m_ea[7:0]);
            reg_rd(REG_EA_HI, rd);
            check(rd, m_ea[15:8]);
            exec(SME_OP_LOAD, 7'h00, 1'b0, 1'(i), 2'(i), 1'b0, 6'h1F);
        end
        exec(SME_OP_COPY, WIN0_ADDR, DEST_FILE, 1'b0, 2'h0, 1'b0, 6'h00);
        exec(SME_OP_SHIFT, WIN1_ADDR, DEST_FILE, 1'b0, 2'h0, 1'b0, 6'h00);
        exec(SME_OP_SHIFT, WIN1_ADDR, DEST_WORK, 1'b0, 2'h0, 1'b0, 6'h00);
        for (int n = 0; n < 400; n++) begin
            r = rnd();
            if (r[31:29] == 3'h0) set_ptr(r[28], r[15:0]);
            exec(sme_op_e'(r[1:0]), r[8:2], r[9], r[10], r[12:11], r[13],
                r[19:14]);
            if (r[27:25] == 3'h0) begin
                reg_rd(REG_STATUS, rd);
                check(rd, {6'h00, m_z, m_c});
            end
        end
        reg_wr(4'hC, 8'hFF);
        reg_rd(4'hA, rd);
        check(rd, 8'h00);
        reg_rd(REG_WORK, rd);
        check(rd, m_work);
        for (int i = 0; i < MEM_DEPTH; i++) begin
            reg_wr(REG_MEM_ADDR, 8'(i));
            reg_rd(REG_MEM_DATA, rd);
            check(rd, m_mem[i]);
        end
        give_verdict();
    end
endmodule : test_sme_exec
`default_nettype wire
